// *** verilog/bus_pins_pkg.sv ***
/*
 * Shared constants and carrier structs for the backplane grant, data and strobe pin logic.
 * Assumes all pins are sampled synchronously to the single system clock.
 */
package bus_pins_pkg;
    localparam int DATA_W = 32;
    localparam int LEVELS = 4;
    localparam int STROBES = 2;
    // Release time for the acknowledge line after it is driven back high.
    localparam int ACK_RESCIND_NS = 8;
    localparam int CLK_NS = 8;
    localparam int ACK_RESCIND_CYC = (ACK_RESCIND_NS + CLK_NS - 1) / CLK_NS;

    // Strobe pair decode, active-low pin levels.
    localparam logic [1:0] STB_BOTH = 2'h0;
    localparam logic [1:0] STB_UPPER = 2'h1;
    localparam logic [1:0] STB_LOWER = 2'h2;
    localparam logic [1:0] STB_NONE = 2'h3;

    // Local master request toward the backplane.
    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] lanes;
        logic [DATA_W-1:0] wdata;
    } mst_req_s;

    // Slave-side transfer seen by local logic.
    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] lanes;
        logic [DATA_W-1:0] wdata;
    } slv_xfer_s;

    typedef enum logic [1:0] {
        LANE_NONE,
        LANE_LOW,
        LANE_HIGH,
        LANE_BOTH
    } lane_e;
endpackage

// *** verilog/bus_pins.sv ***
/*
 * Backplane pin logic: grant daisy chain, data lines, data strobes and transfer acknowledge.
 * Assumes the address decoder elsewhere supplies slave selection and that local logic
 * supplies request level, master request and slave read data.
 */
// Behaviour
// - Take grant only when requesting that level
// - Otherwise pass grant down the chain
// - At most one grant output asserted
// - Data direction high while driving data
// - Strobe direction high while driving strobes
// - Strobe levels select active byte lanes
// - Write data valid at strobe falling edge
// - Read strobe asks slave for data
// - Slave pulls acknowledge low to respond
// - Rescind acknowledge high, release after strobe
// - Address strobe edge marks valid address
`timescale 1ns/1ps
module bus_pins #(
    parameter int DATA_W = bus_pins_pkg::DATA_W
) (
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Grant daisy chain, active low.
    input wire logic [3:0] grant_chain_in_n_in,
    output logic [3:0] grant_chain_out_n_out,
    // Local requester.
    input wire logic req_pending_in,
    input wire logic [1:0] req_level_in,
    output logic grant_taken_out,
    // Local master transfer.
    input wire bus_pins_pkg::mst_req_s mst_req_in,
    output logic mst_done_out,
    output logic [DATA_W-1:0] mst_rdata_out,
    // Local slave side.
    input wire logic slv_selected_in,
    input wire logic [DATA_W-1:0] slv_rdata_in,
    input wire logic slv_ready_in,
    output bus_pins_pkg::slv_xfer_s slv_xfer_out,
    // Data lines.
    input wire logic [DATA_W-1:0] backplane_data_lines_in,
    output logic [DATA_W-1:0] backplane_data_lines_out,
    output logic backplane_data_lines_oe_out,
    output logic data_xcvr_direction_out,
    // Data strobes, active low.
    input wire logic [1:0] backplane_data_strobes_n_in,
    output logic [1:0] backplane_data_strobes_n_out,
    output logic backplane_data_strobes_oe_out,
    output logic strobe_xcvr_direction_out,
    // Address strobe, active low.
    input wire logic address_strobe_pin_n_in,
    output logic address_strobe_pin_n_out,
    output logic address_strobe_pin_oe_out,
    // Transfer acknowledge, active low.
    input wire logic transfer_ack_pin_n_in,
    output logic transfer_ack_pin_n_out,
    output logic transfer_ack_pin_oe_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Grant daisy chain.

    logic [3:0] grant_out_n_r;
    logic grant_taken_r;
    logic [3:0] grant_in_n_d_r;

    // Pins are treated as synchronous; keep the previous level, though the grant logic below does not read it.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            grant_in_n_d_r <= 4'hf;
        end else begin
            grant_in_n_d_r <= grant_chain_in_n_in;
        end
    end

    // Forward or keep the grant per level; a level is kept only if we request it.
    // The arbiter grants one level, so lowest active level wins to keep one-hot.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            grant_out_n_r <= 4'hf;
            grant_taken_r <= 1'b0;
        end else begin
            grant_out_n_r <= 4'hf;
            grant_taken_r <= 1'b0;
            for (int i = 0; i < bus_pins_pkg::LEVELS; i++) begin
                if (!grant_chain_in_n_in[i] && grant_out_n_r == 4'hf && !grant_taken_r ||
                    !grant_chain_in_n_in[i] && (!grant_out_n_r[i] || grant_taken_r)) begin
                    if (req_pending_in && req_level_in == 2'(i)) begin
                        grant_taken_r <= 1'b1;
                    end else begin
                        grant_out_n_r <= ~(4'h1 << i);
                    end
                    break;
                end
            end
        end
    end

    assign grant_chain_out_n_out = grant_out_n_r;
    assign grant_taken_out = grant_taken_r;

    ////////////////////////////////////////////////////////////////////////////
    // Transfer sequencer for master and slave roles.

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_M_ADDR,
        ST_M_STROBE,
        ST_M_END,
        ST_S_WAIT,
        ST_S_ACK,
        ST_S_RESCIND
    } state_e;

    state_e state_r;
    logic [DATA_W-1:0] data_out_r;
    logic data_oe_r;
    logic data_dir_r;
    logic [1:0] stb_out_n_r;
    logic stb_oe_r;
    logic stb_dir_r;
    logic as_out_n_r;
    logic as_oe_r;
    logic ack_out_n_r;
    logic ack_oe_r;
    logic mst_done_r;
    logic [DATA_W-1:0] mst_rdata_r;
    logic write_r;
    logic [1:0] stb_in_n_d_r;
    bus_pins_pkg::slv_xfer_s slv_xfer_r;
    logic [7:0] rescind_cnt_r;

    // Decode the strobe pair into byte lanes, same for both roles.
    function automatic logic [1:0] lanes_of(input logic [1:0] stb_n);
        unique case (stb_n)
            bus_pins_pkg::STB_BOTH: lanes_of = 2'h3;
            bus_pins_pkg::STB_UPPER: lanes_of = 2'h2;
            bus_pins_pkg::STB_LOWER: lanes_of = 2'h1;
            bus_pins_pkg::STB_NONE: lanes_of = 2'h0;
        endcase
    endfunction

    // Previous strobe levels, to find the falling edge as slave.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            stb_in_n_d_r <= 2'h3;
        end else begin
            stb_in_n_d_r <= backplane_data_strobes_n_in;
        end
    end

    logic stb_fall;
    assign stb_fall = (backplane_data_strobes_n_in != bus_pins_pkg::STB_NONE) &&
                      (stb_in_n_d_r == bus_pins_pkg::STB_NONE);

    // Main sequencer; all direction controls follow the drive they go with.
    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            state_r <= ST_IDLE;
            data_out_r <= '0;
            data_oe_r <= 1'b0;
            data_dir_r <= 1'b0;
            stb_out_n_r <= 2'h3;
            stb_oe_r <= 1'b0;
            stb_dir_r <= 1'b0;
            as_out_n_r <= 1'b1;
            as_oe_r <= 1'b0;
            ack_out_n_r <= 1'b1;
            ack_oe_r <= 1'b0;
            mst_done_r <= 1'b0;
            mst_rdata_r <= '0;
            write_r <= 1'b0;
            slv_xfer_r <= '0;
            rescind_cnt_r <= '0;
        end else begin
            mst_done_r <= 1'b0;
            slv_xfer_r.valid <= 1'b0;
            unique case (state_r)
                ST_IDLE: begin
                    data_oe_r <= 1'b0;
                    data_dir_r <= 1'b0;
                    stb_oe_r <= 1'b0;
                    stb_dir_r <= 1'b0;
                    if (grant_taken_r && mst_req_in.valid) begin
                        // Address strobe falls first; the address is valid at that edge.
                        write_r <= mst_req_in.write;
                        as_out_n_r <= 1'b0;
                        as_oe_r <= 1'b1;
                        data_out_r <= mst_req_in.wdata;
                        data_oe_r <= mst_req_in.write;
                        data_dir_r <= mst_req_in.write;
                        stb_dir_r <= 1'b1;
                        stb_oe_r <= 1'b1;
                        stb_out_n_r <= 2'h3;
                        state_r <= ST_M_ADDR;
                    end else if (slv_selected_in && !address_strobe_pin_n_in && stb_fall) begin
                        write_r <= (backplane_data_strobes_n_in != 2'h3) && !slv_ready_in ? 1'b1 : 1'b0;
                        slv_xfer_r.valid <= 1'b1;
                        slv_xfer_r.lanes <= lanes_of(backplane_data_strobes_n_in);
                        slv_xfer_r.wdata <= backplane_data_lines_in;
                        slv_xfer_r.write <= 1'b0;
                        state_r <= ST_S_WAIT;
                    end
                end
                ST_M_ADDR: begin
                    // Write data was put out a cycle before the strobes fall.
                    stb_out_n_r <= ~mst_req_in.lanes;
                    state_r <= ST_M_STROBE;
                end
                ST_M_STROBE: begin
                    if (!transfer_ack_pin_n_in) begin
                        mst_rdata_r <= backplane_data_lines_in;
                        mst_done_r <= 1'b1;
                        stb_out_n_r <= 2'h3;
                        as_out_n_r <= 1'b1;
                        state_r <= ST_M_END;
                    end
                end
                ST_M_END: begin
                    as_oe_r <= 1'b0;
                    stb_oe_r <= 1'b0;
                    stb_dir_r <= 1'b0;
                    data_oe_r <= 1'b0;
                    data_dir_r <= 1'b0;
                    if (transfer_ack_pin_n_in) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_S_WAIT: begin
                    if (slv_ready_in) begin
                        // Read data goes out with the acknowledge in the same edge.
                        data_out_r <= slv_rdata_in;
                        data_oe_r <= 1'b1;
                        data_dir_r <= 1'b1;
                        ack_out_n_r <= 1'b0;
                        ack_oe_r <= 1'b1;
                        state_r <= ST_S_ACK;
                    end
                end
                ST_S_ACK: begin
                    if (backplane_data_strobes_n_in == bus_pins_pkg::STB_NONE) begin
                        data_oe_r <= 1'b0;
                        data_dir_r <= 1'b0;
                        ack_out_n_r <= 1'b1;
                        rescind_cnt_r <= 8'(bus_pins_pkg::ACK_RESCIND_CYC);
                        state_r <= ST_S_RESCIND;
                    end
                end
                ST_S_RESCIND: begin
                    if (rescind_cnt_r != 8'h00) begin
                        rescind_cnt_r <= rescind_cnt_r - 8'h01;
                    end
                    if (rescind_cnt_r == 8'h00 && address_strobe_pin_n_in) begin
                        ack_oe_r <= 1'b0;
                        state_r <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign backplane_data_lines_out = data_out_r;
    assign backplane_data_lines_oe_out = data_oe_r;
    assign data_xcvr_direction_out = data_dir_r;
    assign backplane_data_strobes_n_out = stb_out_n_r;
    assign backplane_data_strobes_oe_out = stb_oe_r;
    assign strobe_xcvr_direction_out = stb_dir_r;
    assign address_strobe_pin_n_out = as_out_n_r;
    assign address_strobe_pin_oe_out = as_oe_r;
    assign transfer_ack_pin_n_out = ack_out_n_r;
    assign transfer_ack_pin_oe_out = ack_oe_r;
    assign mst_done_out = mst_done_r;
    assign mst_rdata_out = mst_rdata_r;
    assign slv_xfer_out = slv_xfer_r;

endmodule

// *** verification/bus_pins_properties.sv ***
/* Checker for the backplane pin block: grant chain, transceiver directions, acknowledge.
   Sees only the block's ports and is bound to every instance of it. */
`timescale 1ns/1ps
module bus_pins_properties (
    // Clock, reset, grant chain and master done.
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic [3:0] grant_chain_in_n_in,
    input wire logic [3:0] grant_chain_out_n_out,
    input wire logic req_pending_in,
    input wire logic [1:0] req_level_in,
    input wire logic grant_taken_out,
    input wire logic mst_done_out,
    // Pins.
    input wire logic backplane_data_lines_oe_out,
    input wire logic data_xcvr_direction_out,
    input wire logic [1:0] backplane_data_strobes_n_in,
    input wire logic [1:0] backplane_data_strobes_n_out,
    input wire logic backplane_data_strobes_oe_out,
    input wire logic strobe_xcvr_direction_out,
    input wire logic address_strobe_pin_n_in,
    input wire logic transfer_ack_pin_n_out,
    input wire logic transfer_ack_pin_oe_out
);
    // All checks share the one clock; all but a_rst are disabled during its reset.
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);
    property p_one_grant; $countones(~grant_chain_out_n_out) <= 1; endproperty
    a_one_grant: assert property (p_one_grant) else $error("several grant outputs low");
    // A fresh grant is judged only on its first cycle, so a held grant cannot confuse it.
    property p_take; req_pending_in && $onehot(~grant_chain_in_n_in) && !grant_chain_in_n_in[req_level_in]
        && $past(grant_chain_in_n_in) == 4'hf |=> grant_taken_out && &grant_chain_out_n_out; endproperty
    a_take: assert property (p_take) else $error("grant at own level not taken");
    property p_pass; !(req_pending_in && !grant_chain_in_n_in[req_level_in]) && $onehot(~grant_chain_in_n_in)
        && $past(grant_chain_in_n_in) == 4'hf |=> grant_chain_out_n_out == $past(grant_chain_in_n_in); endproperty
    a_pass: assert property (p_pass) else $error("grant not passed on");
    property p_ddir; backplane_data_lines_oe_out |-> data_xcvr_direction_out; endproperty
    a_ddir: assert property (p_ddir) else $error("data direction low while driving");
    property p_sdir; backplane_data_strobes_oe_out && backplane_data_strobes_n_out != 2'h3
        |-> strobe_xcvr_direction_out; endproperty
    a_sdir: assert property (p_sdir) else $error("strobe direction low while driving");
    property p_rst; disable iff (1'b0) rst_in |=> !data_xcvr_direction_out && !strobe_xcvr_direction_out
        && &grant_chain_out_n_out; endproperty
    a_rst: assert property (p_rst) else $error("outputs not at rest after reset");
    property p_ack_hold; transfer_ack_pin_oe_out && !transfer_ack_pin_n_out
        && backplane_data_strobes_n_in != 2'h3 |=> !transfer_ack_pin_n_out; endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("acknowledge dropped early");
    property p_rescind; transfer_ack_pin_oe_out && !transfer_ack_pin_n_out |=> transfer_ack_pin_oe_out; endproperty
    a_rescind: assert property (p_rescind) else $error("acknowledge released while low");
    // Once the line is driven high with the address strobe high, it is let go within two cycles.
    property p_release; transfer_ack_pin_oe_out && transfer_ack_pin_n_out && address_strobe_pin_n_in
        |-> ##[1:2] !transfer_ack_pin_oe_out; endproperty
    a_release: assert property (p_release) else $error("acknowledge not released");
    // Main scenarios reached.
    c_taken: cover property (grant_taken_out);
    c_ack: cover property (transfer_ack_pin_oe_out && !transfer_ack_pin_n_out);
    c_done: cover property (mst_done_out);
endmodule
bind bus_pins bus_pins_properties u_bus_pins_properties (.*);

// *** verification/backplane_far_slave.sv ***
/* Behavioural far-side slave on the backplane, answering the block's master cycles.
   Assumes strobes and address strobe resolved by the bench; acknowledge is open collector. */
`timescale 1ns/1ps
module backplane_far_slave #(
    parameter logic [31:0] RDATA = 32'h5a3c_96e1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic en_in,
    input wire logic [3:0] delay_in,
    input wire logic as_n_in,
    input wire logic [1:0] stb_n_in,
    input wire logic [31:0] data_in,
    output logic ack_low_out,
    output logic [31:0] data_out,
    output logic [31:0] wdata_out,
    output logic [1:0] lanes_out
);
    logic [3:0] cnt;
    logic [1:0] prev;
    // Released lines show the inverse, so a stale sample can never look right.
    assign data_out = ack_low_out ? RDATA : ~RDATA;
    // Capture on the strobe fall, acknowledge after the chosen delay, drop on strobes high.
    always @(posedge clk_in) begin
        prev <= stb_n_in;
        if (rst_in || !en_in || as_n_in || stb_n_in == 2'h3) begin
            cnt <= 4'h0;
            ack_low_out <= 1'b0;
        end else begin
            if (prev == 2'h3) begin
                wdata_out <= data_in;
                lanes_out <= ~stb_n_in;
            end
            cnt <= cnt + 4'h1;
            if (cnt == delay_in) ack_low_out <= 1'b1;
        end
    end
endmodule

// *** verification/bus_pins_tb.sv ***
/* Self-checking bench for the backplane pin block with a far-side slave model.
   Assumes inputs change on the falling edge and pulled-up strobe and acknowledge lines. */
`timescale 1ns/1ps
module bus_pins_tb;
    logic sys_clk_in = 0, rst_in = 1, req_pending_in = 0, slv_selected_in = 0, slv_ready_in = 0, tb_as = 1;
    logic [3:0] grant_chain_in_n_in = 4'hf, grant_chain_out_n_out, dly = 4'h1;
    logic [1:0] req_level_in = 0, tb_stb = 2'h3, backplane_data_strobes_n_in, backplane_data_strobes_n_out, m_lanes;
    logic [31:0] slv_rdata_in = 0, mst_rdata_out, backplane_data_lines_in, backplane_data_lines_out, m_data, m_wdata;
    logic grant_taken_out, mst_done_out, backplane_data_lines_oe_out, data_xcvr_direction_out, m_ack;
    logic backplane_data_strobes_oe_out, strobe_xcvr_direction_out, address_strobe_pin_n_in, address_strobe_pin_n_out;
    logic address_strobe_pin_oe_out, transfer_ack_pin_n_in, transfer_ack_pin_n_out, transfer_ack_pin_oe_out;
    bus_pins_pkg::mst_req_s mst_req_in = '0;
    bus_pins_pkg::slv_xfer_s slv_xfer_out;
    int n_fail = 0, checks = 0;
    always #4 sys_clk_in = ~sys_clk_in;
    // Wire levels from all drivers; undriven strobes and acknowledge float high.
    assign backplane_data_strobes_n_in = backplane_data_strobes_oe_out ? backplane_data_strobes_n_out : tb_stb;
    assign address_strobe_pin_n_in = address_strobe_pin_oe_out ? address_strobe_pin_n_out : tb_as;
    assign transfer_ack_pin_n_in = !(m_ack || (transfer_ack_pin_oe_out && !transfer_ack_pin_n_out));
    assign backplane_data_lines_in = backplane_data_lines_oe_out ? backplane_data_lines_out : m_data;
    bus_pins u_bus_pins (.*);
    backplane_far_slave u_backplane_far_slave (.clk_in(sys_clk_in), .rst_in(rst_in),
        .en_in(backplane_data_strobes_oe_out), .delay_in(dly), .as_n_in(address_strobe_pin_n_in),
        .stb_n_in(backplane_data_strobes_n_in), .data_in(backplane_data_lines_in), .ack_low_out(m_ack),
        .data_out(m_data), .wdata_out(m_wdata), .lanes_out(m_lanes));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask
    // One grant at level g with the local request at level r.
    task automatic grant_try(input int g, input int r, input logic t, input logic [3:0] o);
        req_pending_in = 1;
        req_level_in = r[1:0];
        grant_chain_in_n_in = ~(4'h1 << g);
        cyc(2);
        chk("taken", {31'h0, t}, {31'h0, grant_taken_out});
        chk("grant_out", {28'h0, o}, {28'h0, grant_chain_out_n_out});
        grant_chain_in_n_in = 4'hf;
        req_pending_in = 0;
        cyc(2);
    endtask
    task automatic t_grant;
        for (int l = 0; l < 4; l++) begin
            grant_try(l, l, 1, 4'hf);
            grant_try(l, l + 1, 0, ~(4'h1 << l));
        end
        $display("test grant done");
    endtask
    // Master cycle at level 2 with the far slave answering after d cycles.
    task automatic t_master(input logic wr, input logic [1:0] ln, input logic [3:0] d);
        int i;
        dly = d;
        req_pending_in = 1;
        req_level_in = 2'h2;
        grant_chain_in_n_in = 4'hb;
        cyc(2);
        mst_req_in = '{1'b1, wr, ln, 32'hc001_d00d};
        for (i = 0; i < 8 && backplane_data_strobes_n_in == 2'h3; i++) cyc(1);
        chk("strobes", {30'h0, ~ln}, {30'h0, backplane_data_strobes_n_in});
        chk("stb_dir", 1, {31'h0, strobe_xcvr_direction_out});
        chk("data_dir", {31'h0, wr}, {31'h0, data_xcvr_direction_out});
        for (i = 0; i < 20 && mst_done_out !== 1'b1; i++) cyc(1);
        chk("done", 1, {31'h0, mst_done_out});
        if (wr) chk("wdata", 32'hc001_d00d, m_wdata);
        else chk("rdata", 32'h5a3c_96e1, mst_rdata_out);
        chk("lanes", {30'h0, ln}, {30'h0, m_lanes});
        mst_req_in = '0;
        cyc(4);
        grant_chain_in_n_in = 4'hf;
        req_pending_in = 0;
        cyc(2);
        chk("idle_dir", 0, {30'h0, data_xcvr_direction_out, strobe_xcvr_direction_out});
        $display("test master done");
    endtask
    // Slave read of lane 0 from a backplane master played by the bench.
    task automatic t_slave;
        int i;
        tb_as = 0;
        slv_selected_in = 1;
        cyc(1);
        tb_stb = 2'h2;
        for (i = 0; i < 4 && slv_xfer_out.valid !== 1'b1; i++) cyc(1);
        chk("xfer", {29'h0, 3'h5}, {29'h0, slv_xfer_out.valid, slv_xfer_out.lanes});
        slv_rdata_in = 32'h1234_abcd;
        slv_ready_in = 1;
        for (i = 0; i < 4 && transfer_ack_pin_n_in !== 1'b0; i++) cyc(1);
        chk("ack", 0, {31'h0, transfer_ack_pin_n_in});
        chk("sdata", 32'h1234_abcd, backplane_data_lines_in);
        chk("dirs", 32'h2, {30'h0, data_xcvr_direction_out, strobe_xcvr_direction_out});
        cyc(2);
        chk("ack_held", 0, {31'h0, transfer_ack_pin_n_in});
        tb_stb = 2'h3;
        slv_ready_in = 0;
        for (i = 0; i < 4 && transfer_ack_pin_n_out !== 1'b1; i++) cyc(1);
        chk("ack_high", 3, {30'h0, transfer_ack_pin_n_out, transfer_ack_pin_oe_out});
        tb_as = 1;
        slv_selected_in = 0;
        for (i = 0; i < 4 && transfer_ack_pin_oe_out !== 1'b0; i++) cyc(1);
        chk("ack_off", 0, {30'h0, transfer_ack_pin_oe_out, data_xcvr_direction_out});
        $display("test slave done");
    endtask
    // Watchdog far beyond the hundred or so cycles the tests need.
    initial begin
        #40000;
        n_fail++;
        give_verdict();
    end
    initial begin
        cyc(4);
        rst_in = 0;
        chk("reset", 32'h3c, {26'h0, grant_chain_out_n_out, data_xcvr_direction_out, strobe_xcvr_direction_out});
        t_grant();
        t_master(1, 2'h3, 4'h1);
        t_master(1, 2'h1, 4'h4);
        t_master(0, 2'h2, 4'h2);
        t_slave();
        give_verdict();
    end
endmodule
